// ---- pmid_map.svh ----
// register offsets, field positions and reset values of the power monitor
// and part identification block; assumes a 32-bit APB with byte addresses
`ifndef PMID_MAP_SVH
`define PMID_MAP_SVH

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define PMID_OFF_ID_HIGH     4'h0
`define PMID_OFF_ID_LOW      4'h4
`define PMID_OFF_CTRL_1      4'h8
`define PMID_OFF_CTRL_2      4'hC

// ----------------------------------------------------------------
// power_monitor_ctrl_1 fields
// ----------------------------------------------------------------
`define PMID_C1_WARN_FLAG    7
`define PMID_C1_WARN_ACK     6
`define PMID_C1_WARN_IRQ_EN  5
`define PMID_C1_DET_RST_EN   4
`define PMID_C1_DET_STOP_EN  3
`define PMID_C1_DET_EN       2
`define PMID_C1_REF_BUF_EN   0

// ----------------------------------------------------------------
// power_monitor_ctrl_2 fields
// ----------------------------------------------------------------
`define PMID_C2_DET_TRIP     5
`define PMID_C2_WARN_TRIP    4
`define PMID_C2_DS_FLAG      3
`define PMID_C2_DS_ACK       2
`define PMID_C2_DS_SEL       0

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define PMID_RST_REF_BUF_EN  1'h0
`define PMID_RST_IRQ_EN      1'h0
`define PMID_RST_DET_RST_EN  1'h1
`define PMID_RST_DET_STOP_EN 1'h0
`define PMID_RST_DET_EN      1'h1
`define PMID_RST_DS_SEL      1'h0
`define PMID_RST_TRIP        1'h0

`endif

// ---- pmid_pkg.sv ----
// types of the power monitor and part identification block
// assumes nothing of its surroundings
package pmid_pkg;

   typedef logic [31:0] pmid_word_t;
   typedef logic [3:0]  pmid_addr_t;

   // which trip point pair is selected
   typedef enum logic [1:0]
   {
      PMID_TRIP_LOW_A,
      PMID_TRIP_LOW_B,
      PMID_TRIP_HIGH_A,
      PMID_TRIP_HIGH_B
   } pmid_trip_t;

endpackage

// ---- pmid_regs.sv ----
// power monitor controls and part identification registers on APB
// assumes comparators, reset controller and stop sequencer around it
`timescale 1ns/1ps
`include "pmid_map.svh"

// What this block does
// - id pair returns fixed 12-bit part number, high nibble then low byte
// - bit 7 of high id register reads zero, writes ignored
// - bits 6:4 of high id register reserved, writes ignored
// - warning flag sticky: set while or since warning existed
// - ack write clears warning flag only when warning is gone
// - interrupt request while warning flag and irq enable are one
// - detect event forces full reset if reset enable and detect enable
// - stop enable keeps detection alive in stop, only with detect enable
// - detect enable turns detection on, qualifies reset and stop enables
// - bit 0 of ctrl 1 register enables the reference buffer
// - write-once controls other than detect trip select take only the first write after any reset
// - detect trip select is write-once against power-on reset only
// - detect and warning selects pick one of four trip points
// - deep stop flag reads one after recovery from deep stop
// - writing one to deep stop ack clears deep stop flag
// - deep stop select: zero chooses stop3, one chooses stop2
// - warning flag set when supply below warning point, also after reset
module pmid_regs
#(
   parameter logic [11:0] PART_NUMBER = 12'h5A5  // arbitrary value
)
(
   // apb slave
   input  wire logic                pclk,
   input  wire logic                presetn,
   input  wire logic                psel,
   input  wire logic                penable,
   input  wire logic                pwrite,
   input  wire pmid_pkg::pmid_addr_t paddr,
   input  wire pmid_pkg::pmid_word_t pwdata,
   output      pmid_pkg::pmid_word_t prdata,
   output      logic                pready,
   output      logic                pslverr,
   // reset cause, power-on only when low
   input  wire logic                por_n,
   // analog and mode status
   input  wire logic                low_supply_warning,
   input  wire logic                low_supply_detect,
   input  wire logic                in_stop,
   input  wire logic                deep_stop_recovered,
   // controls
   output      logic                irq,
   output      logic                detect_reset_req,
   output      logic                detect_active,
   output      logic                reference_buffer_en,
   output      logic                deep_stop_select,
   output      pmid_pkg::pmid_trip_t trip_select
);
   import pmid_pkg::*;

   localparam int ID_W = 12;
   initial
   begin
      if ($bits(PART_NUMBER) != ID_W)
         $error("part number must be 12 bits");
   end

   // ----------------------------------------------------------------
   // bus decode
   // ----------------------------------------------------------------
   logic       wr_en;
   logic       rd_en;
   logic       hit;
   pmid_word_t rd_word;

   function automatic logic is_addr(input pmid_addr_t a, input pmid_addr_t o);
      is_addr = (a == o);
   endfunction

   assign wr_en = psel & penable & pwrite & ~pready;
   assign rd_en = psel & penable & ~pwrite & ~pready;
   assign hit   = is_addr(paddr, `PMID_OFF_ID_HIGH)
                | is_addr(paddr, `PMID_OFF_ID_LOW)
                | is_addr(paddr, `PMID_OFF_CTRL_1)
                | is_addr(paddr, `PMID_OFF_CTRL_2);

   logic wr_c1;
   logic wr_c2;
   assign wr_c1 = wr_en & is_addr(paddr, `PMID_OFF_CTRL_1);
   assign wr_c2 = wr_en & is_addr(paddr, `PMID_OFF_CTRL_2);

   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   logic warn_flag_ff;
   logic irq_en_ff;
   logic det_rst_en_ff;
   logic det_stop_en_ff;
   logic det_en_ff;
   logic ref_buf_ff;
   logic ds_sel_ff;
   logic ds_flag_ff;
   logic c1_lock_ff;
   logic ds_lock_ff;
   logic det_trip_ff;
   logic warn_trip_ff;
   logic trip_lock_ff;
   logic det_active_now;

   // ----------------------------------------------------------------
   // warning flag
   // ----------------------------------------------------------------
   // set wins over ack; condition present right after reset also sets
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         warn_flag_ff <= 1'h0;
      else if (low_supply_warning)
         warn_flag_ff <= 1'h1;
      else if (wr_c1 && pwdata[`PMID_C1_WARN_ACK])
         warn_flag_ff <= 1'h0;
   end

   // ----------------------------------------------------------------
   // ctrl 1 plain bits
   // ----------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         irq_en_ff  <= `PMID_RST_IRQ_EN;
         ref_buf_ff <= `PMID_RST_REF_BUF_EN;
      end
      else if (wr_c1)
      begin
         irq_en_ff  <= pwdata[`PMID_C1_WARN_IRQ_EN];
         ref_buf_ff <= pwdata[`PMID_C1_REF_BUF_EN];
      end
   end

   // ----------------------------------------------------------------
   // ctrl 1 write-once bits
   // ----------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         det_rst_en_ff  <= `PMID_RST_DET_RST_EN;
         det_stop_en_ff <= `PMID_RST_DET_STOP_EN;
         det_en_ff      <= `PMID_RST_DET_EN;
         c1_lock_ff     <= 1'h0;
      end
      else if (wr_c1 && !c1_lock_ff)
      begin
         det_rst_en_ff  <= pwdata[`PMID_C1_DET_RST_EN];
         det_stop_en_ff <= pwdata[`PMID_C1_DET_STOP_EN];
         det_en_ff      <= pwdata[`PMID_C1_DET_EN];
         c1_lock_ff     <= 1'h1;
      end
   end

   // ----------------------------------------------------------------
   // ctrl 2: deep stop select and flag
   // ----------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         ds_sel_ff  <= `PMID_RST_DS_SEL;
         ds_lock_ff <= 1'h0;
      end
      else if (wr_c2 && !ds_lock_ff)
      begin
         ds_sel_ff  <= pwdata[`PMID_C2_DS_SEL];
         ds_lock_ff <= 1'h1;
      end
   end

   // recovery event wins over ack
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         ds_flag_ff <= 1'h0;
      else if (deep_stop_recovered)
         ds_flag_ff <= 1'h1;
      else if (wr_c2 && pwdata[`PMID_C2_DS_ACK])
         ds_flag_ff <= 1'h0;
   end

   // ----------------------------------------------------------------
   // ctrl 2: trip selects, cleared by power-on only
   // ----------------------------------------------------------------
   // por_n is a synchronous qualifier; presetn alone keeps these
   always_ff @(posedge pclk)
   begin
      if (!por_n)
      begin
         det_trip_ff  <= `PMID_RST_TRIP;
         warn_trip_ff <= `PMID_RST_TRIP;
         trip_lock_ff <= 1'h0;
      end
      else if (presetn && wr_c2)
      begin
         warn_trip_ff <= pwdata[`PMID_C2_WARN_TRIP];
         if (!trip_lock_ff)
         begin
            det_trip_ff  <= pwdata[`PMID_C2_DET_TRIP];
            trip_lock_ff <= 1'h1;
         end
      end
   end

   // ----------------------------------------------------------------
   // detection qualify
   // ----------------------------------------------------------------
   // stop enable and reset enable count only with detect enable
   assign det_active_now = det_en_ff & (~in_stop | det_stop_en_ff);

   // ----------------------------------------------------------------
   // outputs
   // ----------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         irq                 <= 1'h0;
         detect_reset_req    <= 1'h0;
         detect_active       <= 1'h0;
         reference_buffer_en <= 1'h0;
         deep_stop_select    <= 1'h0;
      end
      else
      begin
         irq                 <= warn_flag_ff & irq_en_ff;
         detect_reset_req    <= det_active_now & det_rst_en_ff
                                & low_supply_detect;
         detect_active       <= det_active_now;
         reference_buffer_en <= ref_buf_ff;
         deep_stop_select    <= ds_sel_ff;
      end
   end

   // trip outputs follow the power-on-only selects, untouched by presetn
   always_ff @(posedge pclk)
   begin
      trip_select <= pmid_trip_t'({det_trip_ff, warn_trip_ff});
   end

   // ----------------------------------------------------------------
   // read mux
   // ----------------------------------------------------------------
   always_comb
   begin
      rd_word = '0;
      unique case (paddr)
         `PMID_OFF_ID_HIGH:
            rd_word[3:0] = PART_NUMBER[11:8];
         `PMID_OFF_ID_LOW:
            rd_word[7:0] = PART_NUMBER[7:0];
         `PMID_OFF_CTRL_1:
         begin
            rd_word[`PMID_C1_WARN_FLAG]   = warn_flag_ff;
            rd_word[`PMID_C1_WARN_IRQ_EN] = irq_en_ff;
            rd_word[`PMID_C1_DET_RST_EN]  = det_rst_en_ff;
            rd_word[`PMID_C1_DET_STOP_EN] = det_stop_en_ff;
            rd_word[`PMID_C1_DET_EN]      = det_en_ff;
            rd_word[`PMID_C1_REF_BUF_EN]  = ref_buf_ff;
         end
         `PMID_OFF_CTRL_2:
         begin
            rd_word[`PMID_C2_DET_TRIP]  = det_trip_ff;
            rd_word[`PMID_C2_WARN_TRIP] = warn_trip_ff;
            rd_word[`PMID_C2_DS_FLAG]   = ds_flag_ff;
            rd_word[`PMID_C2_DS_SEL]    = ds_sel_ff;
         end
         default:
            rd_word = '0;
      endcase
   end

   // ----------------------------------------------------------------
   // apb answer, one wait state
   // ----------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         pready  <= 1'h0;
         pslverr <= 1'h0;
         prdata  <= '0;
      end
      else
      begin
         pready  <= wr_en | rd_en;
         pslverr <= (wr_en | rd_en) & ~hit;
         prdata  <= rd_en ? rd_word : '0;
      end
   end

endmodule

// ---- pmid_regs_sva.sv ----
// port assertions of the power monitor and part id register block
// assumes an apb master that holds each request until pready
`timescale 1ns/1ps
module pmid_regs_sva
#(
   parameter logic [11:0] PART_NUMBER = 12'h5A5  // arbitrary value
)
(
   // apb side
   input wire logic pclk, presetn, psel, penable, pwrite, pready, pslverr,
   input wire pmid_pkg::pmid_addr_t paddr,
   input wire pmid_pkg::pmid_word_t pwdata, prdata,
   // status and controls
   input wire logic por_n, low_supply_warning, low_supply_detect, in_stop,
   input wire logic deep_stop_recovered, irq, detect_reset_req,
   input wire logic detect_active, reference_buffer_en, deep_stop_select,
   input wire pmid_pkg::pmid_trip_t trip_select
);
   import pmid_pkg::*;
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   wire       rd = pready && psel && !pwrite;
   wire [7:0] d  = prdata[7:0];
   // ------------------------------------------------------------
   // answer timing and read values
   // ------------------------------------------------------------
   sequence s_first;
      psel && penable && !pready && !$past(penable);
   endsequence
   a_one_wait:
      assert property (s_first |=> pready && pslverr == (paddr[1:0] != 2'h0))
      else $error("access not answered after one wait state");
   a_ready_pulse:
      assert property (pready |=> !pready)
      else $error("pready longer than one cycle");
   a_id_high:
      assert property (rd && paddr == 4'h0 |->
         !d[7] && d[3:0] == PART_NUMBER[11:8])
      else $error("high id read wrong");
   a_id_low:
      assert property (rd && paddr == 4'h4 |-> d == PART_NUMBER[7:0])
      else $error("low id read wrong");
   a_c2_unused:
      assert property (rd && paddr == 4'hC |-> d[7:6] == 2'h0 && d[2:1] == 2'h0)
      else $error("unused ctrl2 bits not zero");
   a_c2_outputs:
      assert property (rd && paddr == 4'hC |->
         deep_stop_select == d[0] && trip_select == d[5:4])
      else $error("ctrl2 outputs differ from register");
   a_irq_level:
      assert property (rd && paddr == 4'h8 |->
         irq == (d[7] && d[5]) && reference_buffer_en == d[0])
      else $error("irq or buffer enable differs from ctrl1");
   a_flag_sticky:
      assert property (rd && paddr == 4'h8 && $past(low_supply_warning, 2)
         && $past(low_supply_warning, 3) |-> d[7])
      else $error("warning flag not set");
   a_reset_req:
      assert property (detect_reset_req |->
         $past(low_supply_detect) && detect_active)
      else $error("reset request without enabled detect");
endmodule
bind pmid_regs pmid_regs_sva #(.PART_NUMBER(PART_NUMBER)) u_pmid_regs_sva (.*);

// ---- pmid_regs_bench.sv ----
// self-checking bench of the power monitor and part id register block
// assumes only the design, its package and its checker
`timescale 1ns/1ps
module pmid_regs_bench;
   import pmid_pkg::*;
   localparam logic [11:0] PN = 12'h5A5;  // arbitrary value
   logic       pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
   logic       por_n = 0, lsw = 0, lsd = 0, stp = 0, dsr = 0;
   pmid_addr_t paddr = 4'h0;
   pmid_word_t pwdata = 32'h0, prdata, rd;
   logic       pready, pslverr, err, irq, drq, act, rbe, dss;
   pmid_trip_t trip;
   int         bad_count = 0, num_checks = 0, cyc = 0;
   logic [7:0] r, c1, c2;
   always #10 pclk = ~pclk;
   pmid_regs #(.PART_NUMBER(PN)) u_pmid_regs (.pclk(pclk),
      .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .por_n(por_n), .low_supply_warning(lsw),
      .low_supply_detect(lsd), .in_stop(stp), .deep_stop_recovered(dsr),
      .irq(irq), .detect_reset_req(drq), .detect_active(act),
      .reference_buffer_en(rbe), .deep_stop_select(dss),
      .trip_select(trip));
   // ------------------------------------------------------------
   // helpers
   // ------------------------------------------------------------
   function automatic logic [7:0] nxt1(input logic [7:0] c, w, input logic k);
      return {2'h0, w[5], k ? c[4:2] : w[4:2], 1'b0, w[0]};
   endfunction
   function automatic logic [7:0] nxt2(input logic [7:0] c, w, input logic k);
      return {2'h0, k ? c[5] : w[5], w[4], 3'h0, k ? c[0] : w[0]};
   endfunction
   task automatic end_of_test();
      if (bad_count == 0 && num_checks > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, exp);
      num_checks++;
      if (got !== exp)
      begin
         bad_count++;
         $display("unexpected at %0t: got %h want %h", $time, got, exp);
      end
   endtask
   task automatic xfer(input logic w, input pmid_addr_t a, input logic [7:0] v);
      int n;
      n = 0;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= {24'h0, v};
      @(posedge pclk);
      penable <= 1'b1;
      do
      begin
         @(posedge pclk);
         n++;
      end
      while (pready !== 1'b1 && n < 20);
      rd = prdata;
      err = pslverr;
      if (n == 20)
      begin
         bad_count++;
         $display("unexpected at %0t: no pready", $time);
      end
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic rchk(input pmid_addr_t a, input logic [7:0] m, e);
      xfer(1'b0, a, 8'h00);
      chk(rd & {24'hFFFFFF, m}, {24'h0, e});
      chk(err, a[1:0] != 2'h0);
   endtask
   task automatic rst(input logic por);
      @(posedge pclk);
      presetn <= 1'b0;
      por_n <= !por;
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      por_n <= 1'b1;
   endtask
   always @(posedge pclk)
   begin
      cyc++;
      if (cyc == 5000)
      begin
         bad_count++;
         end_of_test();
      end
   end
   // ------------------------------------------------------------
   // main sequence
   // ------------------------------------------------------------
   initial
   begin
      void'($urandom(91));
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
      por_n <= 1'b1;
      xfer(1'b1, 4'h0, 8'hFF);
      xfer(1'b1, 4'h4, 8'h00);
      rchk(4'h0, 8'h8F, {4'h0, PN[11:8]});
      rchk(4'h4, 8'hFF, PN[7:0]);
      rchk(4'h8, 8'hFF, 8'h14);
      rchk(4'hC, 8'hFF, 8'h00);
      rchk(4'h3, 8'hFF, 8'h00);
      r = 8'($urandom) | 8'h14;
      c1 = nxt1(8'h14, r, 1'b0);
      xfer(1'b1, 4'h8, r);
      rchk(4'h8, 8'h3D, c1);
      c1 = nxt1(c1, ~r, 1'b1);
      xfer(1'b1, 4'h8, ~r);
      rchk(4'h8, 8'h3D, c1);
      for (int i = 0; i < 2; i++)
      begin
         stp <= i[0];
         lsd <= 1'b1;
         repeat (3) @(posedge pclk);
         chk(act, c1[2] & (!i[0] | c1[3]));
         chk(drq, c1[2] & (!i[0] | c1[3]) & c1[4]);
         chk(rbe, c1[0]);
      end
      lsd <= 1'b0;
      stp <= 1'b0;
      xfer(1'b1, 4'h8, 8'h21);
      lsw <= 1'b1;
      repeat (3) @(posedge pclk);
      chk(irq, 1'b1);
      xfer(1'b1, 4'h8, 8'h61);
      rchk(4'h8, 8'h80, 8'h80);
      lsw <= 1'b0;
      rchk(4'h8, 8'h80, 8'h80);
      xfer(1'b1, 4'h8, 8'h41);
      rchk(4'h8, 8'h80, 8'h00);
      lsw <= 1'b1;
      repeat (3) @(posedge pclk);
      chk(irq, 1'b0);
      r = 8'($urandom);
      c2 = nxt2(8'h00, r, 1'b0);
      xfer(1'b1, 4'hC, r);
      rchk(4'hC, 8'h31, c2);
      c2 = nxt2(c2, ~r, 1'b1);
      xfer(1'b1, 4'hC, ~r);
      rchk(4'hC, 8'h31, c2);
      chk(dss, c2[0]);
      chk(trip, c2[5:4]);
      dsr <= 1'b1;
      @(posedge pclk);
      dsr <= 1'b0;
      rchk(4'hC, 8'h08, 8'h08);
      xfer(1'b1, 4'hC, c2 | 8'h04);
      rchk(4'hC, 8'h0C, 8'h00);
      rst(1'b0);
      rchk(4'hC, 8'hFF, {2'h0, c2[5:4], 4'h0});
      rchk(4'h8, 8'h9D, 8'h94);
      lsw <= 1'b0;
      xfer(1'b1, 4'hC, ~c2);
      rchk(4'hC, 8'h21, {2'h0, c2[5], 4'h0, ~c2[0]});
      rst(1'b1);
      rchk(4'hC, 8'hFF, 8'h00);
      end_of_test();
   end
endmodule
